//--- rtl/i2c_host.v
// Two-wire bus master that reads and writes the clock/calendar registers
`timescale 1ns/1ps
`default_nettype none
`include "i2c_host_regs.vh"

module i2c_host #(
    parameter [`QCNT_W-1:0] QUARTER = `SCL_QUARTER_CYC,
    parameter DEPTH = `FIFO_DEPTH
) (
    input wire mclk,
    input wire rst,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire cmd_read,
    input wire cmd_ptr_en,
    input wire [`PTR_W-1:0] cmd_ptr,
    input wire [7:0] cmd_len,
    input wire [7:0] wr_data,
    input wire wr_valid,
    output wire wr_ready,
    output wire [7:0] rd_data,
    output wire rd_valid,
    output wire busy,
    output wire done,
    output wire nack_err,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe
);

    // ****************************************
    // States and byte kinds
    // ****************************************
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_START = 5'h02;
    localparam [4:0] S_BIT = 5'h04;
    localparam [4:0] S_WAIT = 5'h08;
    localparam [4:0] S_STOP = 5'h10;

    localparam [1:0] K_ADDR = 2'h0;
    localparam [1:0] K_PTR = 2'h1;
    localparam [1:0] K_DATA = 2'h2;

    reg [4:0] state_reg;
    reg [1:0] kind_reg;
    reg [1:0] ph_reg;
    reg [3:0] bit_reg;
    reg [7:0] sh_reg;
    reg [7:0] left_reg;
    reg [`PTR_W-1:0] ptr_reg;
    reg [`QCNT_W-1:0] qcnt_reg;
    reg read_reg;
    reg ptr_pend_reg;
    reg restart_reg;
    reg ack_reg;
    reg scl_oe_reg;
    reg sda_oe_reg;
    reg [7:0] rd_data_reg;
    reg rd_valid_reg;
    reg done_reg;
    reg nack_reg;
    reg scl_meta_reg;
    reg scl_sync_reg;
    reg sda_meta_reg;
    reg sda_sync_reg;

    wire tick;
    wire bus_free;
    wire rx_byte;
    wire more_data;
    wire fifo_valid;
    wire fifo_pop;
    wire [7:0] fifo_data;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Both lines come from outside the clock domain
    always @(posedge mclk) begin
        if (rst) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_i;
            scl_sync_reg <= scl_meta_reg;
            sda_meta_reg <= sda_i;
            sda_sync_reg <= sda_meta_reg;
        end
    end

    // ****************************************
    // Write-data buffer
    // ****************************************
    // Popped only while the engine waits with the clock held low
    assign fifo_pop = state_reg[3];

    sync_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(`FIFO_AW)
    ) wr_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ****************************************
    // Quarter-period divider
    // ****************************************
    // Stopped while idle or waiting so each phase starts a full quarter
    assign tick = (qcnt_reg == QUARTER - 1'b1);

    always @(posedge mclk) begin
        if (rst) begin
            qcnt_reg <= {`QCNT_W{1'b0}};
        end else if (state_reg[0] || state_reg[3] || tick) begin
            qcnt_reg <= {`QCNT_W{1'b0}};
        end else begin
            qcnt_reg <= qcnt_reg + 1'b1;
        end
    end

    // ****************************************
    // Combinational helpers
    // ****************************************
    // A new transfer waits for both lines high
    assign bus_free = scl_sync_reg & sda_sync_reg;
    assign cmd_ready = state_reg[0] & bus_free;
    // We receive only data bytes of a read, after any restart
    assign rx_byte = (kind_reg == K_DATA) & read_reg & ~restart_reg;
    // Data byte counter counts down; zero length closes after the address or pointer byte
    assign more_data = (kind_reg == K_DATA) ? (left_reg != 8'h01)
                       : (left_reg != 8'h00);

    // ****************************************
    // Bus engine
    // ****************************************
    // Four phases per bit: set data, raise clock, sample, lower clock
    always @(posedge mclk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            kind_reg <= K_ADDR;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            left_reg <= 8'h00;
            ptr_reg <= {`PTR_W{1'b0}};
            read_reg <= 1'b0;
            ptr_pend_reg <= 1'b0;
            restart_reg <= 1'b0;
            ack_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            rd_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    scl_oe_reg <= 1'b0;
                    sda_oe_reg <= 1'b0;
                    if (cmd_valid && bus_free) begin
                        read_reg <= cmd_read;
                        ptr_pend_reg <= cmd_ptr_en;
                        ptr_reg <= cmd_ptr;
                        left_reg <= cmd_len;
                        // Pointer then read needs a repeated start
                        restart_reg <= cmd_read & cmd_ptr_en;
                        // Without a pointer write the device reads on from its pointer
                        sh_reg <= {`DEV_ADDR, cmd_ptr_en ? `DIR_WRITE : cmd_read};
                        kind_reg <= K_ADDR;
                        ph_reg <= 2'h0;
                        state_reg <= S_START;
                    end
                end
                S_START: begin
                    if (tick) begin
                        case (ph_reg)
                            2'h0: sda_oe_reg <= 1'b0;
                            2'h1: scl_oe_reg <= 1'b0;
                            2'h2: sda_oe_reg <= 1'b1;
                            default: scl_oe_reg <= 1'b1;
                        endcase
                        ph_reg <= ph_reg + 1'b1;
                        if (ph_reg == 2'h3) begin
                            bit_reg <= 4'h0;
                            state_reg <= S_BIT;
                        end
                    end
                end
                S_BIT: begin
                    if (tick) begin
                        ph_reg <= ph_reg + 1'b1;
                        case (ph_reg)
                            2'h0: begin
                                // Data changes only while the clock is low
                                if (bit_reg == `ACK_SLOT) begin
                                    // Acknowledge every read byte but the last
                                    sda_oe_reg <= rx_byte & more_data;
                                end else begin
                                    sda_oe_reg <= ~rx_byte & ~sh_reg[7];
                                end
                            end
                            2'h1: scl_oe_reg <= 1'b0;
                            2'h2: begin
                                // Sample mid-high; writes shift back their own bits
                                if (bit_reg == `ACK_SLOT) begin
                                    ack_reg <= ~sda_sync_reg;
                                end else begin
                                    sh_reg <= {sh_reg[6:0], sda_sync_reg};
                                end
                            end
                            default: begin
                                scl_oe_reg <= 1'b1;
                                if (bit_reg != `ACK_SLOT) begin
                                    bit_reg <= bit_reg + 1'b1;
                                    if (bit_reg == 4'h7 && rx_byte) begin
                                        rd_data_reg <= sh_reg;
                                        rd_valid_reg <= 1'b1;
                                    end
                                end else if (!rx_byte && !ack_reg) begin
                                    // No answer: address mismatch or refused byte
                                    nack_reg <= 1'b1;
                                    state_reg <= S_STOP;
                                end else begin
                                    // Ninth pulse done; pick the next byte
                                    bit_reg <= 4'h0;
                                    if (kind_reg == K_DATA) begin
                                        left_reg <= left_reg - 1'b1;
                                    end
                                    if (kind_reg == K_ADDR && ptr_pend_reg) begin
                                        // Upper word-address bits go out as zero
                                        kind_reg <= K_PTR;
                                        ptr_pend_reg <= 1'b0;
                                        sh_reg <= {{(8-`PTR_W){1'b0}}, ptr_reg};
                                    end else if (kind_reg == K_PTR && restart_reg) begin
                                        // Repeated start, then read from the new pointer
                                        restart_reg <= 1'b0;
                                        kind_reg <= K_ADDR;
                                        sh_reg <= {`DEV_ADDR, `DIR_READ};
                                        state_reg <= S_START;
                                    end else begin
                                        kind_reg <= K_DATA;
                                        if (!more_data) begin
                                            state_reg <= S_STOP;
                                        end else if (!read_reg) begin
                                            // Device steps its pointer each byte
                                            state_reg <= S_WAIT;
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                S_WAIT: begin
                    // Clock held low until the buffer has a byte
                    if (fifo_valid) begin
                        sh_reg <= fifo_data;
                        ph_reg <= 2'h0;
                        state_reg <= S_BIT;
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        case (ph_reg)
                            2'h0: sda_oe_reg <= 1'b1;
                            2'h1: scl_oe_reg <= 1'b0;
                            2'h2: sda_oe_reg <= 1'b0;
                            default: begin
                                done_reg <= 1'b1;
                                state_reg <= S_IDLE;
                            end
                        endcase
                        ph_reg <= ph_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open drain: the enable pulls low, the level is always zero
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign done = done_reg;
    assign nack_err = nack_reg;
    assign busy = ~state_reg[0];

endmodule // i2c_host

`default_nettype wire

//--- common/i2c_host_regs.vh
// Constants shared by the two-wire host controller and its write-data buffer
`ifndef I2C_HOST_REGS_VH
`define I2C_HOST_REGS_VH

// ****************************************
// Timing
// ****************************************
// System clock period in ns
`define CLK_PERIOD_NS 5
// Serial clock period in ns
`define SCL_PERIOD_NS 2500
// Quarter of a serial clock period in system cycles, rounded down
`define SCL_QUARTER_CYC (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
// Width of the quarter-period counter
`define QCNT_W 16

// ****************************************
// Addressing
// ****************************************
// Seven-bit address of the device on the bus
`define DEV_ADDR 7'h51
// Direction bit values
`define DIR_READ 1'b1
`define DIR_WRITE 1'b0
// Width of the word-address field that the device uses
`define PTR_W 4
// Bit index of the acknowledge slot
`define ACK_SLOT 4'h8

// ****************************************
// Buffering
// ****************************************
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

//--- rtl/sync_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;

    wire push;
    wire pop;

    // Honest flags straight from the fill count
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage needs no reset; only pointers and count do
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth, not at the power of two
    always @(posedge mclk) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // sync_fifo

`default_nettype wire

//--- test/i2c_host_monitor.sv
// Port-level checks on the two-wire host
`timescale 1ns/1ps
`default_nettype none
module i2c_host_monitor #(
    parameter [15:0] QUARTER = 125
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic busy,
    input wire logic done,
    input wire logic nack_err,
    input wire logic rd_valid,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [11:0] pulses;
    // ****************************************
    // Clock pulses since the last start
    // ****************************************
    always @(posedge mclk) begin
        if (rst || ($rose(sda_oe) && !scl_oe)) begin
            pulses <= 12'h000;
        end else if ($fell(scl_oe)) begin
            pulses <= pulses + 12'h001;
        end
    end
    // Delay ranges below assume the short bench quarter of 4 cycles
    AST_OPEN_DRAIN: assert property (scl_o == 1'h0 && sda_o == 1'h0)
        else $error("line driven high");
    AST_IDLE_RELEASED: assert property (!busy |-> !scl_oe && !sda_oe)
        else $error("line pulled while idle");
    AST_TAKE_BUSY: assert property (cmd_valid && cmd_ready |=> busy)
        else $error("command taken without going busy");
    AST_READY_IDLE: assert property (cmd_ready |-> !busy && scl_i)
        else $error("ready while bus not idle");
    AST_START_SHAPE: assert property ($rose(sda_oe) && !scl_oe |-> ##[2:8] $rose(scl_oe))
        else $error("start not followed by clock low");
    AST_STOP_DONE: assert property ($fell(sda_oe) && !scl_oe |-> ##[1:8] done)
        else $error("stop without done");
    AST_BYTE_FRAME: assert property ($fell(sda_oe) && !scl_oe |-> pulses % 9 == 1)
        else $error("frame not whole nine-bit bytes");
    AST_NACK_STOP: assert property (nack_err |-> ##[12:20] done)
        else $error("no stop after missing acknowledge");
    AST_RD_IN_FRAME: assert property (rd_valid |-> busy && scl_oe)
        else $error("read byte outside frame");
    // Main scenarios reached
    AST_COV_READ: cover property (rd_valid);
    AST_COV_NACK: cover property (nack_err);
    AST_COV_DONE: cover property (done);
endmodule // i2c_host_monitor
bind i2c_host i2c_host_monitor #(.QUARTER(QUARTER)) i_mon (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .busy(busy), .done(done),
    .nack_err(nack_err), .rd_valid(rd_valid), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

//--- test/rtc_device_model.sv
// Behavioural clock/calendar slave on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module rtc_device_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic supply_low,
    input wire logic refuse,
    output logic sda_pull
);
    logic [7:0] mem [0:15];
    logic [7:0] sh, tx;
    logic [3:0] ptr;
    logic act, rd, in_addr, first, mack;
    int bitn;
    // Oscillator-stop reset state
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'h00;
        mem[2] = 8'h80;
        ptr = 4'h0;
        act = 1'h0;
        sda_pull = 1'h0;
    end
    // Sticky flag, cleared only by a register write
    always @(posedge supply_low) mem[2][7] = 1'h1;
    // Start resets the bit count; -1 absorbs the clock fall after it
    always @(negedge sda) if (scl === 1'h1) begin
        act = 1'h1;
        in_addr = 1'h1;
        bitn = -1;
        sda_pull = 1'h0;
    end
    // Stop releases everything
    always @(posedge sda) if (scl === 1'h1) begin
        act = 1'h0;
        sda_pull = 1'h0;
    end
    // Sample on the rising clock
    always @(posedge scl) if (act) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else mack = ~sda;
    end
    // Drive changes only while the clock is low
    always @(negedge scl) if (act) begin
        bitn = bitn + 1;
        if (bitn == 8) begin
            if (in_addr) begin
                if (sh[7:1] == 7'h51 && !refuse) begin
                    rd = sh[0];
                    sda_pull = 1'h1;
                end else act = 1'h0;
            end else if (!rd) begin
                sda_pull = 1'h1;
                if (first) ptr = sh[3:0];
                else begin
                    mem[ptr] = sh;
                    ptr = ptr + 4'h1;
                end
                first = 1'h0;
            end else sda_pull = 1'h0;
        end else if (bitn == 9) begin
            bitn = 0;
            sda_pull = 1'h0;
            if (rd && !in_addr && !mack) act = 1'h0;
            else if (rd) begin
                tx = mem[ptr];
                ptr = ptr + 4'h1;
                sda_pull = ~tx[7];
            end
            first = in_addr;
            in_addr = 1'h0;
        end else if (rd && !in_addr) sda_pull = ~tx[7-bitn];
    end
endmodule // rtc_device_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench: host controller against the device model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_read = 1'h0, cmd_ptr_en = 1'h0;
    logic wr_valid = 1'h0, supply_low = 1'h0, refuse = 1'h0, saw_nack;
    logic [3:0] cmd_ptr = 4'h0;
    logic [7:0] cmd_len = 8'h00, wr_data = 8'h00;
    logic [7:0] got [$];
    wire logic cmd_ready, wr_ready, rd_valid, busy, done, nack_err, scl_oe, sda_oe, pull;
    wire logic scl_w, sda_w;
    wire logic [7:0] rd_data;
    int fails = 0, checked = 0, cyc = 0;
    // Open-drain wires with pull-ups
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | pull);
    always #2.5 mclk = ~mclk;
    i2c_host #(.QUARTER(16'h0004), .DEPTH(8)) i_i2c_host (.mclk(mclk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_ptr_en(cmd_ptr_en), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .busy(busy), .done(done), .nack_err(nack_err), .scl_i(scl_w), .scl_o(),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
    rtc_device_model i_rtc_device_model (.scl(scl_w), .sda(sda_w),
        .supply_low(supply_low), .refuse(refuse), .sda_pull(pull));
    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    // One byte into the write buffer, held until accepted
    task automatic push(input logic [7:0] b);
        @(posedge mclk);
        wr_valid <= 1'h1;
        wr_data <= b;
        @(negedge mclk);
        while (wr_ready !== 1'h1) @(negedge mclk);
        @(posedge mclk);
        wr_valid <= 1'h0;
    endtask
    // Offer a command, then collect read bytes until done
    task automatic do_cmd(input logic rd, input logic pe, input logic [3:0] p,
        input logic [7:0] n);
        got.delete();
        saw_nack = 1'h0;
        @(posedge mclk);
        cmd_valid <= 1'h1;
        cmd_read <= rd;
        cmd_ptr_en <= pe;
        cmd_ptr <= p;
        cmd_len <= n;
        @(negedge mclk);
        while (cmd_ready !== 1'h1) @(negedge mclk);
        @(posedge mclk);
        cmd_valid <= 1'h0;
        do begin
            @(negedge mclk);
            if (rd_valid === 1'h1) got.push_back(rd_data);
            if (nack_err === 1'h1) saw_nack = 1'h1;
        end while (done !== 1'h1);
    endtask
    task automatic wr_cmd(input logic [3:0] p, input logic [7:0] d [$]);
        foreach (d[i]) push(d[i]);
        do_cmd(1'h0, 1'h1, p, 8'(d.size()));
        chk1(saw_nack, 1'h0);
    endtask
    task automatic rd_chk(input logic pe, input logic [3:0] p, input logic [7:0] e [$]);
        do_cmd(1'h1, pe, p, 8'(e.size()));
        chk8(8'(got.size()), 8'(e.size()));
        foreach (e[i]) chk8(got[i], e[i]);
    endtask
    task automatic test_reset_flag;
        rd_chk(1'h1, 4'h2, '{8'h80});
        $display("test reset_flag done");
    endtask
    task automatic test_write_read;
        wr_cmd(4'h2, '{8'h15, 8'h33, 8'h47, 8'h5A});
        rd_chk(1'h1, 4'h2, '{8'h15, 8'h33, 8'h47});
        rd_chk(1'h0, 4'h0, '{8'h5A});
        $display("test write_read done");
    endtask
    task automatic test_flag_set;
        @(posedge mclk);
        supply_low <= 1'h1;
        @(posedge mclk);
        supply_low <= 1'h0;
        rd_chk(1'h1, 4'h2, '{8'h95});
        $display("test flag_set done");
    endtask
    // Fill the buffer to refusal, then drain it in one long write
    task automatic test_fill;
        for (int i = 0; i < 8; i++) push(8'hA0 + 8'(i));
        @(negedge mclk);
        chk1(wr_ready, 1'h0);
        // Buffer already holds all eight bytes, so the command only names the count
        do_cmd(1'h0, 1'h1, 4'h8, 8'h08);
        chk1(saw_nack, 1'h0);
        rd_chk(1'h1, 4'h8, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7});
        $display("test fill done");
    endtask
    task automatic test_stall;
        fork
            do_cmd(1'h0, 1'h1, 4'h0, 8'h02);
            begin
                // Late enough that the engine already waits on an empty buffer
                repeat (600) @(posedge mclk);
                @(negedge mclk);
                chk1(busy, 1'h1);
                chk1(scl_oe, 1'h1);
                push(8'hC3);
                push(8'h3C);
            end
        join
        rd_chk(1'h1, 4'h0, '{8'hC3, 8'h3C});
        $display("test stall done");
    endtask
    task automatic test_refuse;
        refuse <= 1'h1;
        do_cmd(1'h0, 1'h1, 4'h5, 8'h00);
        chk1(saw_nack, 1'h1);
        refuse <= 1'h0;
        rd_chk(1'h1, 4'h0, '{8'hC3});
        $display("test refuse done");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        test_reset_flag();
        test_write_read();
        test_flag_set();
        test_fill();
        test_stall();
        test_refuse();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
